// File: pkg/float_conv_regs.vh
// Register map, field positions and timing constants of the format converter
`ifndef FLOAT_CONV_REGS_VH
`define FLOAT_CONV_REGS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define CTRL_OFFSET        8'h00
`define STATUS_OFFSET      8'h04
`define INT_ENABLE_OFFSET  8'h08
`define INT_CLEAR_OFFSET   8'h0C
`define LAST_NATIVE_OFFSET 8'h10
`define LAST_IEEE_OFFSET   8'h14

// ****************************************************************
// Fields
// ****************************************************************
`define CTRL_ENABLE_BIT    0
`define CTRL_RESET         1'h1
`define EVT_NAN_BIT        0
`define EVT_SATURATE_BIT   1
`define EVT_FLUSH_BIT      2
`define EVT_WIDTH          3
`define EVT_RESET          3'h0

// ****************************************************************
// Number formats
// ****************************************************************
`define EXP_ZERO_NATIVE    8'h80
`define EXP_MIN_PAIR_HI    7'h40
`define EXP_MAX_NATIVE     8'h7F
`define BIAS_NORMAL        8'h7F
`define BIAS_NEG_ZERO_FRAC 8'h80
`define IEEE_EXP_ALL_ONES  8'hFF
`define FRAC_HALF          23'h400000
`define NATIVE_ZERO        32'h80000000
`define NATIVE_MAX_POS     32'h7F7FFFFF
`define NATIVE_MAX_NEG     32'h7F800000

// ****************************************************************
// Bus answers
// ****************************************************************
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define REF_CLK_MHZ        10
`define NAN_PULSE_NS       150
// Pulse width rounded up to whole clock cycles
`define NAN_PULSE_CYC      2'h2

`endif

// File: design/float_format_converter.v
// Bus-side converter between native DSP floats and IEEE-754 single precision
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "float_conv_regs.vh"

// Summary of operation
// - Sign 23 to 31, exponent down one
// - Positive normal: exponent plus 7Fh, fraction kept
// - Positive exponent 81h: halved fraction plus 400000h
// - Exponent 80h gives all-zero word
// - Negative exponent 81h, nonzero fraction: negated, halved, plus 400000h
// - Negative zero fraction: exponent plus 80h
// - Negative normal: exponent plus 7Fh, negated fraction
// - Most negative native value becomes negative infinity
// - Exponent bias adds drop the carry
// - Half offset added only in exponent 81h denormals
// - IEEE NaN relocated, not converted
// - NaN conversion raises NaN interrupt
// - Infinities saturate to native extremes
// - Tiny IEEE denormals become native zero
// - Both IEEE zeros give native zero
// - NaN interrupt pulse two cycles (150 ns rounded up)
// - Read converts to native, write to IEEE
module float_format_converter (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // Processor side data bus
  input  wire [31:0] dspDataIn,
  output reg  [31:0] dspDataOut,
  output reg         dspDataOe,
  input  wire        busStrobeN,
  input  wire        busRead,
  // Memory side data bus
  input  wire [31:0] memDataIn,
  output reg  [31:0] memDataOut,
  output reg         memDataOe,
  // Interrupts
  output reg         nanInterrupt,
  output reg         irq,
  // AXI4-Lite write address
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  // AXI4-Lite write data
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  // AXI4-Lite write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // AXI4-Lite read address
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  // AXI4-Lite read data
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready
);

  localparam [1:0] PULSE_LAST = `NAN_PULSE_CYC - 2'h1;

  // ****************************************************************
  // Arithmetic helpers
  // ****************************************************************
  function [7:0] add8;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      add8 = s[7:0];
    end
  endfunction

  function [22:0] neg23;
    input [22:0] f;
    begin
      neg23 = (~f) + 23'h000001;
    end
  endfunction

  // Native to IEEE
  function [31:0] toIeee;
    input [31:0] n;
    reg        sgn;
    reg [7:0]  ex;
    reg [22:0] fr;
    reg        expMinPairFlag;
    reg        expMaxFlag;
    reg        fractionZeroFlag;
    reg        posNormalSelect;
    reg        posSubnormalSelect;
    reg        zeroSelect;
    reg        negSubnormalSelect;
    reg        negZeroFracSelect;
    reg        negNormalSelect;
    reg        negExtremeSelect;
    reg [7:0]  biasedExponentSum;
    reg [23:0] negFull;
    reg [22:0] negatedFractionTerm;
    begin
      ex  = n[31:24];
      sgn = n[23];
      fr  = n[22:0];
      expMinPairFlag   = (ex[7:1] == `EXP_MIN_PAIR_HI);
      expMaxFlag       = (ex == `EXP_MAX_NATIVE);
      fractionZeroFlag = (fr == 23'h000000);
      zeroSelect         = expMinPairFlag & ~ex[0];
      posNormalSelect    = ~expMinPairFlag & ~sgn;
      posSubnormalSelect = expMinPairFlag & ex[0] & ~sgn;
      // A zero fraction outranks the negative denormal for exponent 81h
      negSubnormalSelect = expMinPairFlag & ex[0] & sgn & ~fractionZeroFlag;
      negExtremeSelect   = expMaxFlag & sgn & fractionZeroFlag;
      negZeroFracSelect  = sgn & fractionZeroFlag & ~zeroSelect & ~negExtremeSelect;
      negNormalSelect    = sgn & ~expMinPairFlag & ~fractionZeroFlag;
      if (negZeroFracSelect) begin
        biasedExponentSum = add8(ex, `BIAS_NEG_ZERO_FRAC);
      end else begin
        biasedExponentSum = add8(ex, `BIAS_NORMAL);
      end
      // One shared negator; the half offset only for the denormal case
      negFull = {1'b0, neg23(fr)};
      if (negSubnormalSelect) begin
        negatedFractionTerm = negFull[23:1] + `FRAC_HALF;
      end else begin
        negatedFractionTerm = negFull[22:0];
      end
      if (zeroSelect) begin
        toIeee = 32'h00000000;
      end else if (negExtremeSelect) begin
        toIeee = {1'b1, `IEEE_EXP_ALL_ONES, 23'h000000};
      end else if (posSubnormalSelect) begin
        toIeee = {sgn, 8'h00, {1'b0, fr[22:1]} + `FRAC_HALF};
      end else if (negSubnormalSelect) begin
        toIeee = {sgn, 8'h00, negatedFractionTerm};
      end else if (negZeroFracSelect) begin
        toIeee = {sgn, biasedExponentSum, 23'h000000};
      end else if (negNormalSelect) begin
        toIeee = {sgn, biasedExponentSum, negatedFractionTerm};
      end else if (posNormalSelect) begin
        toIeee = {sgn, biasedExponentSum, fr};
      end else begin
        toIeee = 32'h00000000;
      end
    end
  endfunction

  // IEEE to native
  function [31:0] toNative;
    input [31:0] v;
    reg        sgn;
    reg [7:0]  ex;
    reg [22:0] fr;
    reg [22:0] sh;
    begin
      sgn = v[31];
      ex  = v[30:23];
      fr  = v[22:0];
      sh  = {fr[21:0], 1'b0};
      if (ex == `IEEE_EXP_ALL_ONES) begin
        if (fr != 23'h000000) begin
          toNative = {ex, sgn, fr};
        end else if (sgn) begin
          toNative = `NATIVE_MAX_NEG;
        end else begin
          toNative = `NATIVE_MAX_POS;
        end
      end else if (ex == 8'h00) begin
        if (~fr[22]) begin
          toNative = `NATIVE_ZERO;
        end else if (sgn) begin
          toNative = {`EXP_ZERO_NATIVE | 8'h01, 1'b1, neg23(sh)};
        end else begin
          toNative = {`EXP_ZERO_NATIVE | 8'h01, 1'b0, sh};
        end
      end else if (~sgn) begin
        toNative = {add8(ex, 8'h81), 1'b0, fr};
      end else if (fr == 23'h000000) begin
        toNative = {add8(ex, `BIAS_NEG_ZERO_FRAC), 1'b1, fr};
      end else begin
        toNative = {add8(ex, 8'h81), 1'b1, neg23(fr)};
      end
    end
  endfunction

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  reg        rstMeta;
  reg        rstN;
  reg [33:0] pinMeta;
  reg [33:0] pinSync;
  reg [31:0] dspSync;
  reg [31:0] memMeta;
  reg [31:0] memSync;
  reg        strobePrev;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // Two flops on every pin; data is sampled with its strobe
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta    <= 34'h000000001;
      pinSync    <= 34'h000000001;
      memMeta    <= 32'h00000000;
      memSync    <= 32'h00000000;
      strobePrev <= 1'b0;
    end else begin
      pinMeta    <= {dspDataIn, busRead, busStrobeN};
      pinSync    <= pinMeta;
      memMeta    <= memDataIn;
      memSync    <= memMeta;
      strobePrev <= ~pinSync[0];
    end
  end

  always @* begin
    dspSync = pinSync[33:2];
  end

  // Strobe idles high, so reset leaves no false strobe edge
  wire strobeActive = ~pinSync[0];
  wire readCycle    = pinSync[1];
  wire strobeStart  = strobeActive & ~strobePrev;

  // ****************************************************************
  // Conversion datapath
  // ****************************************************************
  reg        ctrlEnable;
  wire [31:0] nativeResult = toNative(memSync);
  wire [31:0] ieeeResult   = toIeee(dspSync);
  wire        ieeeNan      = (memSync[30:23] == `IEEE_EXP_ALL_ONES) &&
                             (memSync[22:0] != 23'h000000);
  wire        ieeeInf      = (memSync[30:23] == `IEEE_EXP_ALL_ONES) &&
                             (memSync[22:0] == 23'h000000);
  wire        ieeeTiny     = (memSync[30:23] == 8'h00) && ~memSync[22] &&
                             (memSync[22:0] != 23'h000000);
  wire        nativeExtreme = (dspSync[31:24] == `EXP_MAX_NATIVE) && dspSync[23] &&
                              (dspSync[22:0] == 23'h000000);
  wire        convOn   = strobeActive & ctrlEnable;
  wire        doRead   = convOn & readCycle;
  wire        doWrite  = convOn & ~readCycle;
  wire        evtValid = strobeStart & ctrlEnable;

  reg [`EVT_WIDTH-1:0] events;
  reg [31:0]           lastNative;
  reg [31:0]           lastIeee;

  always @* begin
    events = `EVT_RESET;
    if (evtValid && readCycle) begin
      events[`EVT_NAN_BIT]      = ieeeNan;
      events[`EVT_SATURATE_BIT] = ieeeInf;
      events[`EVT_FLUSH_BIT]    = ieeeTiny;
    end else if (evtValid) begin
      events[`EVT_SATURATE_BIT] = nativeExtreme;
    end
  end

  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      dspDataOut <= 32'h00000000;
      dspDataOe  <= 1'b0;
      memDataOut <= 32'h00000000;
      memDataOe  <= 1'b0;
      lastNative <= 32'h00000000;
      lastIeee   <= 32'h00000000;
    end else begin
      dspDataOe <= doRead;
      memDataOe <= doWrite;
      if (doRead) begin
        dspDataOut <= nativeResult;
        lastNative <= nativeResult;
        lastIeee   <= memSync;
      end
      if (doWrite) begin
        memDataOut <= ieeeResult;
        lastNative <= dspSync;
        lastIeee   <= ieeeResult;
      end
    end
  end

  // ****************************************************************
  // NaN pulse and summary interrupt
  // ****************************************************************
  reg [1:0]            pulseCount;
  reg [`EVT_WIDTH-1:0] status;
  reg [`EVT_WIDTH-1:0] intEnable;
  reg [`EVT_WIDTH-1:0] clearReq;
  reg [`EVT_WIDTH-1:0] next_status;

  // Whole cycles only: the half cycle is rounded up
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pulseCount   <= 2'h0;
      nanInterrupt <= 1'b0;
    end else if (events[`EVT_NAN_BIT]) begin
      pulseCount   <= PULSE_LAST;
      nanInterrupt <= 1'b1;
    end else if (pulseCount != 2'h0) begin
      pulseCount   <= pulseCount - 2'h1;
    end else begin
      nanInterrupt <= 1'b0;
    end
  end

  // New events win over a clear in the same cycle
  always @* begin
    next_status = (status & ~clearReq) | events;
  end

  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      status <= `EVT_RESET;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & intEnable);
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  reg        awHave;
  reg        wHave;
  reg [7:0]  wrAddr;
  reg [31:0] wrData;
  reg [3:0]  wrStrb;
  reg [31:0] readMux;
  reg        readHit;
  reg        writeHit;

  always @* begin
    readHit = 1'b1;
    case (araddr)
      `CTRL_OFFSET:        readMux = {31'h00000000, ctrlEnable};
      `STATUS_OFFSET:      readMux = {29'h00000000, status};
      `INT_ENABLE_OFFSET:  readMux = {29'h00000000, intEnable};
      `INT_CLEAR_OFFSET:   readMux = 32'h00000000;
      `LAST_NATIVE_OFFSET: readMux = lastNative;
      `LAST_IEEE_OFFSET:   readMux = lastIeee;
      default: begin
        readMux = 32'h00000000;
        readHit = 1'b0;
      end
    endcase
    case (wrAddr)
      `CTRL_OFFSET, `STATUS_OFFSET, `INT_ENABLE_OFFSET,
      `INT_CLEAR_OFFSET, `LAST_NATIVE_OFFSET, `LAST_IEEE_OFFSET: writeHit = 1'b1;
      default: writeHit = 1'b0;
    endcase
  end

  wire doRegWrite = awHave & wHave & ~bvalid;

  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      awready    <= 1'b0;
      wready     <= 1'b0;
      awHave     <= 1'b0;
      wHave      <= 1'b0;
      wrAddr     <= 8'h00;
      wrData     <= 32'h00000000;
      wrStrb     <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
      ctrlEnable <= `CTRL_RESET;
      intEnable  <= `EVT_RESET;
      clearReq   <= `EVT_RESET;
    end else begin
      clearReq <= `EVT_RESET;
      if (awready && awvalid) begin
        awready <= 1'b0;
        awHave  <= 1'b1;
        wrAddr  <= awaddr;
      end else if (!awHave && !bvalid) begin
        awready <= 1'b1;
      end
      if (wready && wvalid) begin
        wready <= 1'b0;
        wHave  <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end else if (!wHave && !bvalid) begin
        wready <= 1'b1;
      end
      if (doRegWrite) begin
        awHave <= 1'b0;
        wHave  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= writeHit ? `RESP_OKAY : `RESP_SLVERR;
        if (wrStrb[0]) begin
          case (wrAddr)
            `CTRL_OFFSET:       ctrlEnable <= wrData[`CTRL_ENABLE_BIT];
            `INT_ENABLE_OFFSET: intEnable  <= wrData[`EVT_WIDTH-1:0];
            `INT_CLEAR_OFFSET:  clearReq   <= wrData[`EVT_WIDTH-1:0];
            default:            clearReq   <= `EVT_RESET;
          endcase
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (arready && arvalid) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= readMux;
        rresp   <= readHit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

endmodule // float_format_converter

// File: verif/ffc_checker.sv
// Assertions on the converter's data pins and NaN interrupt
`timescale 1ns/1ps
module ffc_checker (
  // Clock and reset
  input wire        ref_clk,
  input wire        resetn,
  // Processor side
  input wire [31:0] dspDataIn,
  input wire [31:0] dspDataOut,
  input wire        dspDataOe,
  input wire        busRead,
  // Memory side
  input wire [31:0] memDataIn,
  input wire [31:0] memDataOut,
  input wire        memDataOe,
  // Interrupt
  input wire        nanInterrupt
);
  reg  [31:0] nat1, nat2, nat3, iee1, iee2, iee3;
  wire [7:0]  ne  = nat3[31:24];
  wire [7:0]  ie  = iee3[30:23];
  wire        ifz = (iee3[22:0] == 23'h000000);
  wire [22:0] ngf = ~nat3[22:0] + 23'h000001;
  // ****
  // Input copies aligned with the three-edge output latency
  // ****
  always @(posedge ref_clk) begin
    nat1 <= dspDataIn;
    nat2 <= nat1;
    nat3 <= nat2;
    iee1 <= memDataIn;
    iee2 <= iee1;
    iee3 <= iee2;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_sign_moved: assert property (memDataOe && ne != 8'h80 |->
    memDataOut[31] == nat3[23]) else $error("sign bit misplaced");
  a_pos_normal: assert property (memDataOe && !nat3[23] && ne != 8'h80 && ne != 8'h81
    |-> memDataOut == {1'b0, ne + 8'h7F, nat3[22:0]}) else $error("positive normal wrong");
  a_pos_denorm: assert property (memDataOe && !nat3[23] && ne == 8'h81 |->
    memDataOut == {9'h000, {1'b0, nat3[22:1]} + 23'h400000}) else $error("denormal wrong");
  a_zero_first: assert property (memDataOe && ne == 8'h80 |->
    memDataOut == 32'h00000000) else $error("native zero not zero");
  a_neg_frac: assert property (memDataOe && nat3[23] && ne != 8'h80 && !(nat3[22:0] == 23'h0)
    |-> memDataOut[22:0] == (ne == 8'h81 ? {1'b0, ngf[22:1]} + 23'h400000 : ngf))
    else $error("negated fraction wrong");
  a_neg_zfrac: assert property (memDataOe && nat3[23] && nat3[22:0] == 23'h0 && ne != 8'h80
    && ne != 8'h7F |-> memDataOut == {1'b1, ne + 8'h80, 23'h0}) else $error("zero fraction wrong");
  a_neg_inf: assert property (memDataOe && nat3 == 32'h7F800000 |->
    memDataOut == 32'hFF800000) else $error("no negative infinity");
  a_dir_read: assert property (dspDataOe |-> !memDataOe && $past(busRead, 3))
    else $error("drive against direction");
  a_nan_reloc: assert property (dspDataOe && ie == 8'hFF && !ifz |->
    dspDataOut == {ie, iee3[31], iee3[22:0]}) else $error("NaN not relocated");
  a_nan_pulse: assert property ($rose(nanInterrupt) |-> ie == 8'hFF && !ifz
    ##1 nanInterrupt ##1 !nanInterrupt) else $error("NaN pulse wrong");
  a_inf_sat: assert property (dspDataOe && ie == 8'hFF && ifz |->
    dspDataOut == (iee3[31] ? 32'h7F800000 : 32'h7F7FFFFF)) else $error("infinity wrong");
  a_tiny_zero: assert property (dspDataOe && ie == 8'h00 && !iee3[22] |->
    dspDataOut == 32'h80000000) else $error("tiny value not zero");
  c_nan: cover property ($rose(nanInterrupt));
  c_neg_inf: cover property (memDataOe && nat3 == 32'h7F800000);
  c_denorm: cover property (memDataOe && ne == 8'h81);
endmodule // ffc_checker

bind float_format_converter ffc_checker chk (.ref_clk(ref_clk), .resetn(resetn),
  .dspDataIn(dspDataIn), .dspDataOut(dspDataOut), .dspDataOe(dspDataOe), .busRead(busRead),
  .memDataIn(memDataIn), .memDataOut(memDataOut), .memDataOe(memDataOe),
  .nanInterrupt(nanInterrupt));

// File: verif/mem_model.sv
// IEEE-side memory model facing the converter
`timescale 1ns/1ps
module mem_model (
  // Clock
  input  wire        ref_clk,
  // Bus control
  input  wire        busStrobeN,
  input  wire        busRead,
  // Converter memory port
  input  wire [31:0] memDataOut,
  input  wire        memDataOe,
  output wire [31:0] memDataIn,
  // Bench side
  input  wire [31:0] readWord,
  output reg  [31:0] storedWord
);
  reg [31:0] lastWord = 32'h00000000;
  // Released bus shows the inverse so stale data never matches
  assign memDataIn = (!busStrobeN && busRead) ? readWord : ~lastWord;
  always @(posedge ref_clk) begin
    if (!busStrobeN && busRead) lastWord <= readWord;
    if (memDataOe) storedWord <= memDataOut;
  end
endmodule // mem_model

// File: verif/tb.sv
// Self-checking bench for the float format converter
`timescale 1ns/1ps
`include "float_conv_regs.vh"
module tb;
  reg         ref_clk    = 1'b0;
  reg         resetn     = 1'b0;
  reg  [31:0] dspDataIn  = 32'h00000000;
  reg         busStrobeN = 1'b1;
  reg         busRead    = 1'b0;
  reg  [31:0] readWord   = 32'h00000000;
  reg  [7:0]  awaddr     = 8'h00;
  reg  [31:0] wdata      = 32'h00000000;
  reg  [7:0]  araddr     = 8'h00;
  reg         awvalid    = 1'b0;
  reg         wvalid     = 1'b0;
  reg         arvalid    = 1'b0;
  wire [31:0] dspDataOut, memDataIn, memDataOut, rdata, storedWord;
  wire [1:0]  bresp, rresp;
  wire        dspDataOe, memDataOe, nanInterrupt, irq;
  wire        awready, wready, bvalid, arready, rvalid;
  integer     errors   = 0;
  integer     compares = 0;

  always #50 ref_clk = ~ref_clk;

  float_format_converter uut (.ref_clk(ref_clk), .resetn(resetn),
    .dspDataIn(dspDataIn), .dspDataOut(dspDataOut), .dspDataOe(dspDataOe),
    .busStrobeN(busStrobeN), .busRead(busRead), .memDataIn(memDataIn),
    .memDataOut(memDataOut), .memDataOe(memDataOe), .nanInterrupt(nanInterrupt), .irq(irq),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(1'b1));

  mem_model memory (.ref_clk(ref_clk), .busStrobeN(busStrobeN), .busRead(busRead),
    .memDataOut(memDataOut), .memDataOe(memDataOe), .memDataIn(memDataIn),
    .readWord(readWord), .storedWord(storedWord));

  // ****
  // Reference conversions
  // ****
  function [31:0] toIeee(input [31:0] n);
    reg [22:0] ng;
    begin
      ng = ~n[22:0] + 23'h000001;
      if (n[31:24] == 8'h80) toIeee = 32'h00000000;
      else if (n == 32'h7F800000) toIeee = 32'hFF800000;
      else if (!n[23] && n[31:24] == 8'h81) toIeee = {9'h000, {1'b0, n[22:1]} + 23'h400000};
      else if (!n[23]) toIeee = {1'b0, n[31:24] + 8'h7F, n[22:0]};
      else if (n[22:0] == 23'h0) toIeee = {1'b1, n[31:24] + 8'h80, 23'h000000};
      else if (n[31:24] == 8'h81) toIeee = {9'h100, {1'b0, ng[22:1]} + 23'h400000};
      else toIeee = {1'b1, n[31:24] + 8'h7F, ng};
    end
  endfunction

  // Negative denormals are left out of the read table
  function [31:0] toNative(input [31:0] v);
    begin
      if (v[30:23] == 8'hFF && v[22:0] != 23'h0) toNative = {v[30:23], v[31], v[22:0]};
      else if (v[30:23] == 8'hFF) toNative = v[31] ? 32'h7F800000 : 32'h7F7FFFFF;
      else if (v[30:23] == 8'h00) toNative = v[22] ? {9'h102, v[21:0], 1'b0} : 32'h80000000;
      else if (!v[31]) toNative = {v[30:23] + 8'h81, 1'b0, v[22:0]};
      else if (v[22:0] == 23'h0) toNative = {v[30:23] + 8'h80, 1'b1, 23'h000000};
      else toNative = {v[30:23] + 8'h81, 1'b1, ~v[22:0] + 23'h000001};
    end
  endfunction

  // ****
  // Shared tasks
  // ****
  task results;
    begin
      $display("Comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask

  task checkEq(input [31:0] got, input [31:0] ex);
    begin
      compares = compares + 1;
      if (got !== ex) begin
        errors = errors + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, ex);
      end
    end
  endtask

  task guard(input integer n);
    begin
      if (n > 60) begin
        errors = errors + 1;
        $display("MISMATCH at %0t: wait ran out", $time);
        results;
      end
    end
  endtask

  task axiWrite(input [7:0] a, input [31:0] d, input [1:0] er);
    integer n;
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      n = 0;
      while (n >= 0) begin
        @(posedge ref_clk);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        if (bvalid === 1'b1) begin
          checkEq({30'h0, bresp}, {30'h0, er});
          n = -1;
        end else begin
          n = n + 1;
          guard(n);
        end
      end
    end
  endtask

  task axiRead(input [7:0] a, input [31:0] ed, input [1:0] er);
    integer n;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      n = 0;
      while (n >= 0) begin
        @(posedge ref_clk);
        if (arready === 1'b1) arvalid <= 1'b0;
        if (rvalid === 1'b1) begin
          checkEq(rdata, ed);
          checkEq({30'h0, rresp}, {30'h0, er});
          n = -1;
        end else begin
          n = n + 1;
          guard(n);
        end
      end
    end
  endtask

  // One strobe cycle; the output is judged at the first edge it is driven
  task convert(input rd, input [31:0] word, input [31:0] ex);
    integer n;
    begin
      busRead <= rd;
      busStrobeN <= 1'b0;
      if (rd) readWord <= word;
      else dspDataIn <= word;
      n = 0;
      while ((rd ? dspDataOe : memDataOe) !== 1'b1) begin
        @(posedge ref_clk);
        n = n + 1;
        guard(n);
      end
      #1;
      checkEq(rd ? dspDataOut : storedWord, ex);
      @(posedge ref_clk);
      busStrobeN <= 1'b1;
      n = 0;
      while ((rd ? dspDataOe : memDataOe) !== 1'b0) begin
        @(posedge ref_clk);
        n = n + 1;
        guard(n);
      end
    end
  endtask

  task wr(input [31:0] n); convert(1'b0, n, toIeee(n)); endtask
  task rd(input [31:0] v); convert(1'b1, v, toNative(v)); endtask

  task waitIrq(input e);
    integer n;
    begin
      n = 0;
      while (irq !== e) begin
        @(posedge ref_clk);
        n = n + 1;
        guard(n);
      end
      checkEq({31'h0, irq}, {31'h0, e});
    end
  endtask

  // ****
  // Scenarios
  // ****
  task regReset;
    begin
      axiRead(`CTRL_OFFSET, 32'h00000001, `RESP_OKAY);
      axiRead(`STATUS_OFFSET, 32'h00000000, `RESP_OKAY);
      axiRead(`INT_ENABLE_OFFSET, 32'h00000000, `RESP_OKAY);
      axiRead(`INT_CLEAR_OFFSET, 32'h00000000, `RESP_OKAY);
      axiRead(8'h40, 32'h00000000, `RESP_SLVERR);
      axiWrite(8'h40, 32'hFFFFFFFF, `RESP_SLVERR);
      axiWrite(`STATUS_OFFSET, 32'h00000007, `RESP_OKAY);
      axiRead(`STATUS_OFFSET, 32'h00000000, `RESP_OKAY);
    end
  endtask

  task writeCases;
    begin
      wr(32'h05123456);
      wr(32'h90400001);
      wr(32'h81234567);
      wr(32'h80000000);
      wr(32'h80800000);
      wr(32'h81812345);
      wr(32'h03800000);
      wr(32'h81800000);
      wr(32'h03ABCDEF);
      wr(32'h7F800000);
      wr(32'h7F800001);
      axiRead(`LAST_NATIVE_OFFSET, 32'h7F800001, `RESP_OKAY);
      axiRead(`LAST_IEEE_OFFSET, 32'hFF7FFFFF, `RESP_OKAY);
    end
  endtask

  task readCases;
    begin
      rd(32'h3F800000);
      rd(32'hC0400000);
      rd(32'hBF800000);
      rd(32'h00600000);
      rd(32'h00100000);
      rd(32'h00000000);
      rd(32'h80000000);
      rd(32'h7F800000);
      rd(32'hFF800000);
      rd(32'hFFC00005);
      axiRead(`STATUS_OFFSET, 32'h00000007, `RESP_OKAY);
    end
  endtask

  task nanIrq;
    begin
      axiWrite(`INT_ENABLE_OFFSET, 32'h00000001, `RESP_OKAY);
      waitIrq(1'b1);
      axiWrite(`INT_CLEAR_OFFSET, 32'h00000001, `RESP_OKAY);
      waitIrq(1'b0);
      axiRead(`STATUS_OFFSET, 32'h00000006, `RESP_OKAY);
      rd(32'h7FC00001);
      waitIrq(1'b1);
      axiWrite(`INT_ENABLE_OFFSET, 32'h00000000, `RESP_OKAY);
      waitIrq(1'b0);
      axiWrite(`INT_CLEAR_OFFSET, 32'h00000007, `RESP_OKAY);
      axiRead(`STATUS_OFFSET, 32'h00000000, `RESP_OKAY);
      axiWrite(`CTRL_OFFSET, 32'h00000000, `RESP_OKAY);
      axiRead(`CTRL_OFFSET, 32'h00000000, `RESP_OKAY);
      axiWrite(`CTRL_OFFSET, 32'h00000001, `RESP_OKAY);
    end
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    regReset;
    writeCases;
    readCases;
    nanIrq;
    results;
  end
endmodule // tb
